// *** pps_consts.svh ***
// constants of the port power sequencer: clock, times, thresholds, register map
`ifndef PPS_CONSTS_SVH
`define PPS_CONSTS_SVH

`define PPS_CLK_HZ 100000000
`define PPS_CLK_MHZ 100

`define PPS_LOCKOUT_TIME_US 2500
`define PPS_FAULT_TIME_US 60000
`define PPS_DISC_TIME_US 350000
`define PPS_STARTUP_TIME_US 60000
`define PPS_CLASS_TIME_US 10000
`define PPS_MARK_TIME_US 10000
`define PPS_CADENCE_TIME_US 2000000
`define PPS_FLASH_TIME_US 250000
`define PPS_GAP_TIME_US 1000000

`define PPS_FAULT_DEC_DIV 16
`define PPS_PWM_HZ 25000
`define PPS_PWM_DUTY_DIV 16

`define PPS_STARTUP_LIMIT_MA 420
`define PPS_C5_B_CUT_MA 748
`define PPS_C5_B_LIMIT_MA 850
`define PPS_C5_A_CUT_MA 792
`define PPS_C5_A_LIMIT_MA 900
`define PPS_C5_AB_CUT_MA 836
`define PPS_C5_AB_LIMIT_MA 950
`define PPS_CLS03_LIMIT_MA 400
`define PPS_CLS4_LIMIT_MA 720
`define PPS_CUT_NUM 7
`define PPS_CUT_DEN 8

`define PPS_CLS_GE8 0
`define PPS_CLS_GE16 1
`define PPS_CLS_GE25 2
`define PPS_CLS_GE35 3
`define PPS_CLS_GT45 4
`define PPS_CLS_GE51 5

`define PPS_REG_CTRL 4'h0
`define PPS_REG_STATUS 4'h4
`define PPS_REG_FAULT 4'h8
`define PPS_CTRL_PORT_DIS 0
`define PPS_CTRL_CLR_CODE 1
`define PPS_STAT_CLASS_LSB 0
`define PPS_STAT_C5_EN 3
`define PPS_STAT_PORT_ON 4
`define PPS_STAT_OC_CODE 5
`define PPS_STAT_SIG_CODE 6
`define PPS_STAT_AC_MODE 7
`define PPS_STAT_STATE_LSB 8

`endif

// *** pps_pkg.sv ***
// types shared by the port power sequencer files
package pps_pkg;

  typedef enum logic [9:0] {
    PPS_ST_RESET   = 10'h001,
    PPS_ST_DETECT  = 10'h002,
    PPS_ST_CLASS1  = 10'h004,
    PPS_ST_MARK1   = 10'h008,
    PPS_ST_MARK2   = 10'h010,
    PPS_ST_CLASS2  = 10'h020,
    PPS_ST_STARTUP = 10'h040,
    PPS_ST_POWERED = 10'h080,
    PPS_ST_COOL    = 10'h100,
    PPS_ST_WAIT    = 10'h200
  } pps_state_t;

  typedef enum logic [1:0] {
    PPS_PROBE_OFF    = 2'h0,
    PPS_PROBE_DETECT = 2'h1,
    PPS_PROBE_CLASS  = 2'h2,
    PPS_PROBE_MARK   = 2'h3
  } pps_probe_t;

  typedef struct packed {
    logic over_limit;
    logic over_cut;
    logic dc_below;
    logic ac_below;
  } pps_cmp_t;

  typedef struct packed {
    logic cadence;
    logic high_cap;
    logic ac_mode;
  } pps_strap_t;

  typedef struct packed {
    logic [9:0] limit_ma;
    logic [9:0] cut_ma;
  } pps_thr_t;

  typedef struct packed {
    logic valid;
    logic [2:0] cls;
  } pps_class_t;

endpackage

// *** pps_lamp.sv ***
// status lamp driver: steady light, blink codes of two or five flashes, dimming pwm
`timescale 1ns/10ps
`include "pps_consts.svh"

module pps_lamp #(
  parameter int unsigned FLASH_CYC = `PPS_FLASH_TIME_US * `PPS_CLK_MHZ,
  parameter int unsigned GAP_CYC = `PPS_GAP_TIME_US * `PPS_CLK_MHZ
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic steady_i,
  input wire logic code2_i,
  input wire logic code5_i,
  input wire logic dim_en_i,
  output logic lamp_sink_o
);

  localparam logic [11:0] PWM_PERIOD = 12'(`PPS_CLK_HZ / `PPS_PWM_HZ);
  localparam logic [11:0] PWM_ON = 12'(`PPS_CLK_HZ / `PPS_PWM_HZ / `PPS_PWM_DUTY_DIV);

  logic [11:0] pwm_cnt_ff;
  logic [31:0] tm_ff;
  logic [2:0] idx_ff;
  logic lit_ff;
  logic gap_ff;
  logic lamp_ff;
  logic active;
  logic [2:0] last_idx;
  logic expire;
  logic raw;

  //////////////////////////////////////////////////////////////////////////////
  // free-running dimming wave, high for one sixteenth of each period
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pwm_cnt_ff <= 12'h000;
    end else if (pwm_cnt_ff == PWM_PERIOD - 12'h001) begin
      pwm_cnt_ff <= 12'h000;
    end else begin
      pwm_cnt_ff <= pwm_cnt_ff + 12'h001;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // blink sequencer; overcurrent code outranks the signature code
  assign active = code2_i | code5_i;
  assign last_idx = code2_i ? 3'h1 : 3'h4;
  assign expire = (tm_ff == (gap_ff ? GAP_CYC : FLASH_CYC) - 32'h1);

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tm_ff <= 32'h0;
      idx_ff <= 3'h0;
      lit_ff <= 1'b1;
      gap_ff <= 1'b0;
    end else if (!active) begin
      tm_ff <= 32'h0;
      idx_ff <= 3'h0;
      lit_ff <= 1'b1;
      gap_ff <= 1'b0;
    end else if (!expire) begin
      tm_ff <= tm_ff + 32'h1;
    end else begin
      tm_ff <= 32'h0;
      if (gap_ff) begin
        gap_ff <= 1'b0;
        lit_ff <= 1'b1;
        idx_ff <= 3'h0;
      end else if (lit_ff) begin
        lit_ff <= 1'b0;
      end else if (idx_ff >= last_idx) begin
        gap_ff <= 1'b1;
      end else begin
        idx_ff <= idx_ff + 3'h1;
        lit_ff <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // lamp output
  assign raw = active ? (lit_ff & ~gap_ff) : steady_i;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lamp_ff <= 1'b0;
    end else begin
      lamp_ff <= raw & (~dim_en_i | (pwm_cnt_ff < PWM_ON));
    end
  end

  assign lamp_sink_o = lamp_ff;

endmodule

// *** pps_port_power_sequencer.sv ***
// port power sequencer: detection, classification, startup, fault and disconnect control
//
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`include "pps_consts.svh"

module pps_port_power_sequencer #(
  parameter int unsigned LOCKOUT_CYC = `PPS_LOCKOUT_TIME_US * `PPS_CLK_MHZ,
  parameter int unsigned FAULT_CYC = `PPS_FAULT_TIME_US * `PPS_CLK_MHZ,
  parameter int unsigned DISC_CYC = `PPS_DISC_TIME_US * `PPS_CLK_MHZ,
  parameter int unsigned STARTUP_CYC = `PPS_STARTUP_TIME_US * `PPS_CLK_MHZ,
  parameter int unsigned CLASS_CYC = `PPS_CLASS_TIME_US * `PPS_CLK_MHZ,
  parameter int unsigned MARK_CYC = `PPS_MARK_TIME_US * `PPS_CLK_MHZ,
  parameter int unsigned CADENCE_CYC = `PPS_CADENCE_TIME_US * `PPS_CLK_MHZ,
  parameter int unsigned FLASH_CYC = `PPS_FLASH_TIME_US * `PPS_CLK_MHZ,
  parameter int unsigned GAP_CYC = `PPS_GAP_TIME_US * `PPS_CLK_MHZ
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // chip-level controls and supervisors
  input wire logic en_i,
  input wire logic supply_lockout_flag_i,
  input wire logic supply_overvoltage_flag_i,
  input wire logic overtemp_flag_i,
  // straps and selects; a floating pin reads high
  input wire logic class5_select_a_i,
  input wire logic class5_select_b_i,
  input wire logic lamp_dimming_enable_i,
  input wire logic disconnect_mode_strap_i,
  input wire logic cadence_mode_strap_i,
  input wire logic high_cap_strap_i,
  // analog front end results
  input pps_pkg::pps_cmp_t cmp_i,
  input wire logic [5:0] class_ge_i,
  input wire logic det_done_i,
  input wire logic det_valid_i,
  input wire logic det_bad_sig_i,
  // register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wr_data_i,
  input wire logic reg_wr_en_i,
  input wire logic reg_rd_en_i,
  output logic [31:0] reg_rd_data_o,
  // port and analog controls
  output logic port_on_o,
  output pps_pkg::pps_probe_t probe_output_o,
  output pps_pkg::pps_thr_t thr_o,
  output logic high_cap_en_o,
  output logic ac_disconnect_en_o,
  output logic lamp_sink_o,
  output logic lamp_out_o
);

  pps_pkg::pps_state_t state_ff;
  pps_pkg::pps_state_t nxt_state;
  pps_pkg::pps_strap_t strap_ff;
  pps_pkg::pps_probe_t probe_ff;
  pps_pkg::pps_thr_t thr_ff;
  pps_pkg::pps_class_t dec;
  logic [31:0] lockout_cnt_ff;
  logic [31:0] tmr_ff;
  logic [31:0] fault_cnt_ff;
  logic [31:0] disc_cnt_ff;
  logic [7:0] dec_div_ff;
  logic [2:0] cls_ff;
  logic code2_ff;
  logic code5_ff;
  logic port_dis_ff;
  logic port_ff;
  logic [31:0] rd_data_ff;
  logic core_hold;
  logic c5_en;
  logic on_state;
  logic startup_entry;
  logic over;
  logic dec_tick;
  logic fault_hit;
  logic below;
  logic disc_hit;
  logic sw_clr;
  logic [31:0] status_word;
  logic [12:0] cut_calc;

  // class decode of the thermometer flags; the 45-51 mA gap resolves to class 5 when class 5 is enabled, else to class 4
  function automatic pps_pkg::pps_class_t decode_class(input logic [5:0] ge, input logic c5);
    pps_pkg::pps_class_t r;
    r.valid = 1'b1;
    r.cls = 3'h0;
    if (ge[`PPS_CLS_GE51] && !c5) begin
      r.valid = 1'b0;
    end else if (ge[`PPS_CLS_GT45] && c5) begin
      r.cls = 3'h5;
    end else if (ge[`PPS_CLS_GE35]) begin
      r.cls = 3'h4;
    end else if (ge[`PPS_CLS_GE25]) begin
      r.cls = 3'h3;
    end else if (ge[`PPS_CLS_GE16]) begin
      r.cls = 3'h2;
    end else if (ge[`PPS_CLS_GE8]) begin
      r.cls = 3'h1;
    end
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // internal reset: lockout qualification, enable pin, overtemperature
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lockout_cnt_ff <= 32'h0;
    end else if (!supply_lockout_flag_i) begin
      lockout_cnt_ff <= 32'h0;
    end else if (lockout_cnt_ff != LOCKOUT_CYC) begin
      lockout_cnt_ff <= lockout_cnt_ff + 32'h1;
    end
  end

  // the flag must have been seen on LOCKOUT_CYC + 1 edges, i.e. strictly longer
  assign core_hold = !(supply_lockout_flag_i && lockout_cnt_ff == LOCKOUT_CYC)
    || !en_i || overtemp_flag_i;

  // straps follow their pins only while held in reset
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap_ff <= 3'h0;
    end else if (core_hold) begin
      strap_ff <= {cadence_mode_strap_i, high_cap_strap_i, disconnect_mode_strap_i};
    end
  end

  assign c5_en = !(class5_select_a_i && class5_select_b_i);

  //////////////////////////////////////////////////////////////////////////////
  // port sequencing
  assign dec = decode_class(class_ge_i, c5_en);
  assign on_state = (state_ff == pps_pkg::PPS_ST_STARTUP) || (state_ff == pps_pkg::PPS_ST_POWERED);
  assign startup_entry = (nxt_state == pps_pkg::PPS_ST_STARTUP) &&
    (state_ff != pps_pkg::PPS_ST_STARTUP);
  assign over = (state_ff == pps_pkg::PPS_ST_STARTUP) ? cmp_i.over_limit : cmp_i.over_cut;
  assign dec_tick = (dec_div_ff == 8'(`PPS_FAULT_DEC_DIV - 1));
  assign fault_hit = on_state && over && (fault_cnt_ff == FAULT_CYC - 32'h1);
  assign below = strap_ff.ac_mode ? cmp_i.ac_below : cmp_i.dc_below;
  assign disc_hit = (state_ff == pps_pkg::PPS_ST_POWERED) && below &&
    (disc_cnt_ff == DISC_CYC);

  always_comb begin
    nxt_state = state_ff;
    if (core_hold) begin
      nxt_state = pps_pkg::PPS_ST_RESET;
    end else begin
      unique case (state_ff)
        pps_pkg::PPS_ST_RESET: begin
          nxt_state = pps_pkg::PPS_ST_DETECT;
        end
        pps_pkg::PPS_ST_DETECT: begin
          if (det_done_i) begin
            nxt_state = det_valid_i ? pps_pkg::PPS_ST_CLASS1 : pps_pkg::PPS_ST_WAIT;
          end
        end
        pps_pkg::PPS_ST_CLASS1: begin
          if (tmr_ff == CLASS_CYC - 32'h1) begin
            if (!dec.valid) begin
              nxt_state = pps_pkg::PPS_ST_WAIT;
            end else if (dec.cls >= 3'h4) begin
              nxt_state = pps_pkg::PPS_ST_MARK1;
            end else begin
              nxt_state = pps_pkg::PPS_ST_STARTUP;
            end
          end
        end
        pps_pkg::PPS_ST_MARK1: begin
          if (tmr_ff == MARK_CYC - 32'h1) begin
            nxt_state = pps_pkg::PPS_ST_MARK2;
          end
        end
        pps_pkg::PPS_ST_MARK2: begin
          if (tmr_ff == MARK_CYC - 32'h1) begin
            nxt_state = pps_pkg::PPS_ST_CLASS2;
          end
        end
        pps_pkg::PPS_ST_CLASS2: begin
          if (tmr_ff == CLASS_CYC - 32'h1) begin
            nxt_state = dec.valid ? pps_pkg::PPS_ST_STARTUP : pps_pkg::PPS_ST_WAIT;
          end
        end
        pps_pkg::PPS_ST_STARTUP: begin
          if (tmr_ff == STARTUP_CYC - 32'h1) begin
            nxt_state = pps_pkg::PPS_ST_POWERED;
          end
        end
        pps_pkg::PPS_ST_POWERED: begin
          nxt_state = pps_pkg::PPS_ST_POWERED;
        end
        pps_pkg::PPS_ST_COOL: begin
          if (fault_cnt_ff == 32'h0 && !supply_overvoltage_flag_i && !port_dis_ff) begin
            nxt_state = pps_pkg::PPS_ST_DETECT;
          end
        end
        pps_pkg::PPS_ST_WAIT: begin
          if (!strap_ff.cadence || tmr_ff == CADENCE_CYC - 32'h1) begin
            nxt_state = pps_pkg::PPS_ST_DETECT;
          end
        end
      endcase
      // every power-off except an internal reset passes through cool-down so the duty limit holds
      if (fault_hit || disc_hit) begin
        nxt_state = pps_pkg::PPS_ST_COOL;
      end
      if (supply_overvoltage_flag_i || port_dis_ff) begin
        nxt_state = pps_pkg::PPS_ST_COOL;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= pps_pkg::PPS_ST_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // phase timer restarts on every state change
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tmr_ff <= 32'h0;
    end else if (nxt_state != state_ff) begin
      tmr_ff <= 32'h0;
    end else begin
      tmr_ff <= tmr_ff + 32'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // overcurrent fault counter and disconnect timer
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dec_div_ff <= 8'h00;
    end else if (dec_tick) begin
      dec_div_ff <= 8'h00;
    end else begin
      dec_div_ff <= dec_div_ff + 8'h01;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fault_cnt_ff <= 32'h0;
    end else if (core_hold || startup_entry) begin
      fault_cnt_ff <= 32'h0;
    end else if (on_state && over) begin
      if (fault_cnt_ff != FAULT_CYC) begin
        fault_cnt_ff <= fault_cnt_ff + 32'h1;
      end
    end else if (dec_tick && fault_cnt_ff != 32'h0) begin
      fault_cnt_ff <= fault_cnt_ff - 32'h1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      disc_cnt_ff <= 32'h0;
    end else if (startup_entry || state_ff != pps_pkg::PPS_ST_POWERED || !below) begin
      disc_cnt_ff <= 32'h0;
    end else if (disc_cnt_ff != DISC_CYC) begin
      disc_cnt_ff <= disc_cnt_ff + 32'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // class result and current thresholds
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cls_ff <= 3'h0;
    end else if (core_hold) begin
      cls_ff <= 3'h0;
    end else if (state_ff == pps_pkg::PPS_ST_CLASS1 && tmr_ff == CLASS_CYC - 32'h1) begin
      cls_ff <= dec.cls;
    end
  end

  assign cut_calc = 13'((cls_ff == 3'h4 ? `PPS_CLS4_LIMIT_MA : `PPS_CLS03_LIMIT_MA) *
    `PPS_CUT_NUM / `PPS_CUT_DEN);

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      thr_ff <= 20'h0;
    end else if (state_ff != pps_pkg::PPS_ST_POWERED) begin
      thr_ff.limit_ma <= 10'(`PPS_STARTUP_LIMIT_MA);
      thr_ff.cut_ma <= 10'(`PPS_STARTUP_LIMIT_MA);
    end else if (cls_ff == 3'h5) begin
      if (!class5_select_a_i && !class5_select_b_i) begin
        thr_ff.limit_ma <= 10'(`PPS_C5_AB_LIMIT_MA);
        thr_ff.cut_ma <= 10'(`PPS_C5_AB_CUT_MA);
      end else if (!class5_select_a_i) begin
        thr_ff.limit_ma <= 10'(`PPS_C5_A_LIMIT_MA);
        thr_ff.cut_ma <= 10'(`PPS_C5_A_CUT_MA);
      end else begin
        thr_ff.limit_ma <= 10'(`PPS_C5_B_LIMIT_MA);
        thr_ff.cut_ma <= 10'(`PPS_C5_B_CUT_MA);
      end
    end else begin
      thr_ff.limit_ma <= 10'(cls_ff == 3'h4 ? `PPS_CLS4_LIMIT_MA : `PPS_CLS03_LIMIT_MA);
      thr_ff.cut_ma <= cut_calc[9:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // port drive, probe mode and blink codes
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port_ff <= 1'b0;
      probe_ff <= pps_pkg::PPS_PROBE_OFF;
    end else begin
      port_ff <= (nxt_state == pps_pkg::PPS_ST_STARTUP) ||
        (nxt_state == pps_pkg::PPS_ST_POWERED);
      unique case (nxt_state)
        pps_pkg::PPS_ST_DETECT: probe_ff <= pps_pkg::PPS_PROBE_DETECT;
        pps_pkg::PPS_ST_CLASS1, pps_pkg::PPS_ST_CLASS2: probe_ff <= pps_pkg::PPS_PROBE_CLASS;
        pps_pkg::PPS_ST_MARK1, pps_pkg::PPS_ST_MARK2: probe_ff <= pps_pkg::PPS_PROBE_MARK;
        default: probe_ff <= pps_pkg::PPS_PROBE_OFF;
      endcase
    end
  end

  // a new event on the clear cycle keeps its code
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      code2_ff <= 1'b0;
      code5_ff <= 1'b0;
    end else if (core_hold) begin
      code2_ff <= 1'b0;
      code5_ff <= 1'b0;
    end else begin
      if (fault_hit) begin
        code2_ff <= 1'b1;
      end else if (sw_clr || state_ff == pps_pkg::PPS_ST_POWERED) begin
        code2_ff <= 1'b0;
      end
      if (state_ff == pps_pkg::PPS_ST_DETECT && det_done_i && det_bad_sig_i) begin
        code5_ff <= 1'b1;
      end else if (sw_clr || (state_ff == pps_pkg::PPS_ST_DETECT && det_done_i && det_valid_i)) begin
        code5_ff <= 1'b0;
      end
    end
  end

  pps_lamp #(
    .FLASH_CYC(FLASH_CYC),
    .GAP_CYC(GAP_CYC)
  ) u_lamp (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .steady_i(state_ff == pps_pkg::PPS_ST_POWERED),
    .code2_i(code2_ff),
    .code5_i(code5_ff),
    .dim_en_i(lamp_dimming_enable_i),
    .lamp_sink_o(lamp_sink_o)
  );

  //////////////////////////////////////////////////////////////////////////////
  // register port
  assign sw_clr = reg_wr_en_i && reg_addr_i == `PPS_REG_CTRL && reg_wr_data_i[`PPS_CTRL_CLR_CODE];

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port_dis_ff <= 1'b0;
    end else if (reg_wr_en_i && reg_addr_i == `PPS_REG_CTRL) begin
      port_dis_ff <= reg_wr_data_i[`PPS_CTRL_PORT_DIS];
    end
  end

  always_comb begin
    status_word = 32'h0;
    status_word[`PPS_STAT_CLASS_LSB +: 3] = cls_ff;
    status_word[`PPS_STAT_C5_EN] = c5_en;
    status_word[`PPS_STAT_PORT_ON] = port_ff;
    status_word[`PPS_STAT_OC_CODE] = code2_ff;
    status_word[`PPS_STAT_SIG_CODE] = code5_ff;
    status_word[`PPS_STAT_AC_MODE] = strap_ff.ac_mode;
    status_word[`PPS_STAT_STATE_LSB +: 10] = state_ff;
  end

  // read data stand for one cycle only and are zero otherwise
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_ff <= 32'h0;
    end else if (!reg_rd_en_i) begin
      rd_data_ff <= 32'h0;
    end else begin
      unique case (reg_addr_i)
        `PPS_REG_CTRL: rd_data_ff <= {31'h0, port_dis_ff};
        `PPS_REG_STATUS: rd_data_ff <= status_word;
        `PPS_REG_FAULT: rd_data_ff <= fault_cnt_ff;
        default: rd_data_ff <= 32'h0;
      endcase
    end
  end

  assign reg_rd_data_o = rd_data_ff;
  assign port_on_o = port_ff;
  assign probe_output_o = probe_ff;
  assign thr_o = thr_ff;
  assign high_cap_en_o = strap_ff.high_cap;
  assign ac_disconnect_en_o = strap_ff.ac_mode;
  assign lamp_out_o = 1'b0;

endmodule

// *** pps_pd_model.sv ***
// powered device on the cable: signature, class current and load comparators
`timescale 1ns/10ps
module pps_pd_model (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input pps_pkg::pps_probe_t probe_output_i,
  input wire logic port_on_i,
  input wire logic [5:0] cls_ge_i,
  input wire logic [1:0] dly_i,
  input wire logic bad_i,
  input wire logic ovl_i,
  input wire logic gone_i,
  output logic det_done_o,
  output logic det_valid_o,
  output logic det_bad_sig_o,
  output logic [5:0] class_ge_o,
  output pps_pkg::pps_cmp_t cmp_o
);
  logic [1:0] wait_ff;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      wait_ff <= 2'h0;
    else if (probe_output_i != pps_pkg::PPS_PROBE_DETECT || det_done_o)
      wait_ff <= 2'h0;
    else
      wait_ff <= wait_ff + 2'h1;
  end
  // a slow answer stands for a longer slope measurement
  assign det_done_o = probe_output_i == pps_pkg::PPS_PROBE_DETECT && wait_ff == dly_i;
  assign det_valid_o = det_done_o && !bad_i;
  assign det_bad_sig_o = det_done_o && bad_i;
  // outside the class probe the band flags read as junk
  assign class_ge_o = probe_output_i == pps_pkg::PPS_PROBE_CLASS ? cls_ge_i : ~cls_ge_i;
  // no load current flows while the port is unpowered
  assign cmp_o = {{2{port_on_i && ovl_i}}, {2{!port_on_i || gone_i}}};
endmodule

// *** pps_port_power_sequencer_props.sv ***
// assertions on the port power sequencer ports
`timescale 1ns/10ps
module pps_port_power_sequencer_props #(
  parameter int unsigned FAULT_CYC = 50
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  input wire logic supply_lockout_flag_i,
  input wire logic supply_overvoltage_flag_i,
  input wire logic overtemp_flag_i,
  input wire logic disconnect_mode_strap_i,
  input pps_pkg::pps_cmp_t cmp_i,
  input wire logic reg_rd_en_i,
  input wire logic [31:0] reg_rd_data_o,
  input wire logic port_on_o,
  input pps_pkg::pps_thr_t thr_o,
  input wire logic ac_disconnect_en_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [7:0] ovr_ff;
  // consecutive powered cycles above both thresholds
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      ovr_ff <= 8'h0;
    else if (port_on_o && cmp_i.over_limit && cmp_i.over_cut)
      ovr_ff <= ovr_ff + 8'h1;
    else
      ovr_ff <= 8'h0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  chk_ov_port_off: assert property (supply_overvoltage_flag_i |=> !port_on_o)
    else $error("port on under overvoltage");
  chk_temp_port_off: assert property (overtemp_flag_i |=> !port_on_o)
    else $error("port on under overtemperature");
  chk_lockout_hold: assert property (!supply_lockout_flag_i |=> !port_on_o)
    else $error("port on below lockout");
  chk_startup_limit: assert property ($rose(port_on_o) |=> thr_o.limit_ma == 10'h1a4)
    else $error("startup limit wrong");
  chk_fault_bound: assert property (ovr_ff <= FAULT_CYC)
    else $error("overload outlived fault time");
  chk_cool_hold: assert property (ovr_ff == FAULT_CYC |-> !port_on_o [*8])
    else $error("port back on during cool down");
  chk_strap_latch: assert property (!en_i |=> ac_disconnect_en_o == $past(disconnect_mode_strap_i))
    else $error("mode strap not latched in reset");
  chk_strap_keep: assert property (port_on_o |-> $stable(ac_disconnect_en_o))
    else $error("mode strap changed while running");
  chk_read_idle: assert property (!reg_rd_en_i |=> reg_rd_data_o == 32'h0)
    else $error("read data outside answer cycle");
  cover property ($rose(port_on_o));
  cover property (ovr_ff == FAULT_CYC);
  cover property (supply_overvoltage_flag_i && port_on_o);
endmodule
bind pps_port_power_sequencer pps_port_power_sequencer_props #(.FAULT_CYC(FAULT_CYC))
  i_pps_port_power_sequencer_props (.*);

// *** pps_port_power_sequencer_test.sv ***
// self-checking bench of the port power sequencer with a powered device model
`timescale 1ns/10ps
`define CHK(g, e) check(32'(g), 32'(e))
module pps_port_power_sequencer_test;
  logic ref_clk_i = 0, rst_n_i = 0, en_i = 1, ov = 0, hold = 0, strap = 0, bad = 0, ovl = 0;
  logic gone = 0, wr = 0, rd = 0, rd_d = 0, mk = 0, pon, dd, dv, db, acen, hc, lmp;
  logic [1:0] sel = 2'h3, dly = 2'h0;
  logic [5:0] cls = 6'h0, cge;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdat = 32'h0, rdat;
  logic [63:0] nt, exp_q[$];
  pps_pkg::pps_probe_t probe;
  pps_pkg::pps_thr_t thr;
  pps_pkg::pps_cmp_t cmp;
  int error_cnt = 0, total_checks = 0;
  logic [1:0] sa[6] = '{2'h3, 2'h3, 2'h2, 2'h1, 2'h0, 2'h3};
  logic [5:0] cg[6] = '{6'h07, 6'h1f, 6'h1f, 6'h3f, 6'h3f, 6'h00};
  logic [2:0] cl[6] = '{3'h3, 3'h4, 3'h5, 3'h5, 3'h5, 3'h0};
  logic [19:0] th[6] = '{20'h6415e, 20'hb4276, 20'hd4aec, 20'he1318, 20'hedb44, 20'h6415e};
  pps_port_power_sequencer #(.LOCKOUT_CYC(20), .FAULT_CYC(50), .DISC_CYC(30), .STARTUP_CYC(40),
    .CLASS_CYC(10), .MARK_CYC(10), .CADENCE_CYC(20), .FLASH_CYC(8), .GAP_CYC(20))
    i_pps_port_power_sequencer (.ref_clk_i, .rst_n_i, .en_i, .supply_lockout_flag_i(!hold),
    .supply_overvoltage_flag_i(ov), .overtemp_flag_i(hold), .class5_select_a_i(sel[1]),
    .class5_select_b_i(sel[0]), .lamp_dimming_enable_i(strap), .disconnect_mode_strap_i(strap),
    .cadence_mode_strap_i(strap), .high_cap_strap_i(strap), .cmp_i(cmp), .class_ge_i(cge),
    .det_done_i(dd), .det_valid_i(dv), .det_bad_sig_i(db), .reg_addr_i(addr),
    .reg_wr_data_i(wdat), .reg_wr_en_i(wr), .reg_rd_en_i(rd), .reg_rd_data_o(rdat),
    .port_on_o(pon), .probe_output_o(probe), .thr_o(thr), .high_cap_en_o(hc),
    .ac_disconnect_en_o(acen), .lamp_sink_o(lmp), .lamp_out_o());
  pps_pd_model i_pps_pd_model (.ref_clk_i, .rst_n_i, .probe_output_i(probe), .port_on_i(pon),
    .cls_ge_i(cls), .dly_i(dly), .bad_i(bad), .ovl_i(ovl), .gone_i(gone), .det_done_o(dd),
    .det_valid_o(dv), .det_bad_sig_o(db), .class_ge_o(cge), .cmp_o(cmp));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // a read notes its expected word and mask; the monitor compares the answer
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [31:0] m);
    if (!w)
      exp_q.push_back({d, m});
    addr <= a;
    wdat <= d;
    wr <= w;
    rd <= !w;
    @(posedge ref_clk_i);
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  // c 0: port off, else normal powered; returns at a rising edge
  task automatic wait_st(input int c, input int n);
    int k;
    for (k = 0; k < n; k++) begin
      @(negedge ref_clk_i);
      if (c == 0 ? pon === 1'b0 : pon === 1'b1 && thr.limit_ma !== 10'h1a4)
        break;
    end
    if (k == n) begin
      error_cnt++;
      conclude();
    end
    @(posedge ref_clk_i);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk_i) rd_d <= rd;
  // remembers a mark probe since the last enable drop
  always @(posedge ref_clk_i) mk <= en_i && (mk || probe == pps_pkg::PPS_PROBE_MARK);
  always @(negedge ref_clk_i) begin
    if (rd_d) begin
      nt = exp_q.pop_front();
      `CHK(rdat & nt[31:0], nt[63:32]);
    end
  end
  initial forever #5 ref_clk_i = ~ref_clk_i;
  initial begin
    int i;
    int k;
    k = $urandom(45);
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    for (i = 0; i < 6; i++) begin
      if (i == 5) begin
        k = $urandom % 3;
        cg[5] = 6'((1 << k) - 1);
        cl[5] = 3'(k);
      end
      en_i <= 1'b0;
      strap <= i[0];
      sel <= sa[i];
      cls <= cg[i];
      dly <= 2'($urandom);
      @(posedge ref_clk_i);
      en_i <= 1'b1;
      wait_st(1, 400);
      `CHK(thr, th[i]);
      `CHK(acen, i[0]);
      `CHK(hc, i[0]);
      `CHK(lmp | i[0], 1);
      `CHK(mk, cl[i] > 3);
      strap <= !i[0];
      bus(0, 4'h4, {14'h0, 10'h080, i[0], 3'h1, sa[i] != 2'h3, cl[i]}, 32'hffffffff);
      gone <= 1'b1;
      repeat (30) @(posedge ref_clk_i);
      `CHK(pon, 1);
      wait_st(0, 2);
      gone <= 1'b0;
      $display("class test %0d done", i);
    end
    wait_st(1, 400);
    ovl <= 1'b1;
    repeat (48) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    `CHK(pon, 1);
    wait_st(0, 4);
    ovl <= 1'b0;
    repeat (500) @(posedge ref_clk_i);
    `CHK(pon, 0);
    bus(0, 4'h4, {14'h0, 10'h100, 3'h5, 2'h0, cl[5]}, 32'hffffffbf);
    wait_st(1, 800);
    $display("fault test done");
    hold <= 1'b1;
    strap <= 1'b1;
    wait_st(0, 3);
    hold <= 1'b0;
    wait_st(1, 400);
    ov <= 1'b1;
    wait_st(0, 3);
    ov <= 1'b0;
    bus(1, 4'h0, 32'h1, 32'h0);
    bus(0, 4'h0, 32'h1, 32'h1);
    bus(0, 4'hc, 32'h0, 32'hffffffff);
    bad <= 1'b1;
    bus(1, 4'h0, 32'h0, 32'h0);
    repeat (20) @(posedge ref_clk_i);
    bus(0, 4'h4, 32'h40, 32'h50);
    $display("supervisor and register test done");
    conclude();
  end
endmodule
